// ---- rtl/mfe_pkg.sv ----
// What this block does
// - Current gain codes 000..101 give gain 1..32; reset code 011 (gain 8)
// - Voltage gain field at bits 26-24, same mapping, resets to gain 8
// - Reserved gain codes 110 and 111 act exactly as gain 1
// - Converter in soft reset keeps running but delivers only zero samples
// - Reset field bits 6-5: 11 both, 10 voltage, 01 current, 00 none
// - Shutdown field bits 4-3: 11 both, 10 voltage, 01 current, 00 none
// - Clearing shutdown brings back biases, clock and logic of that converter
// - Reference trim byte at bits 23-16, read/write, resets to 0x42
// - Baud field bits 15-13 selects 1200..115200; default 000 is 115200
// - Baud code takes effect only at power-up, from saved configuration
// - Older versions without baud field always run at 115200
// - Bit 12 set inverts the zero-crossing output
// - Bit 11 set gives 100 us pulses per crossing, clear toggles
// - Bit 10 set disables the zero-crossing pin
// - Bit 8 set enables single-wire automatic transmission
// - Bit 7 set enables temperature compensation of measurements
// - Bit 2 set disables the internal voltage reference
// - Unimplemented bits 31-30, 9 and 1-0 always read zero
// - Energy bit 1 accumulates; 0 stops and clears all energy registers
// - Power range byte 23-16 right-shifts active and reactive power alike
// - Bytes 15-8 and 7-0 right-shift RMS current and RMS voltage
package mfe_pkg;
  // Register byte offsets
  localparam logic [7:0]  CFG_OFS     = 8'h00;
  localparam logic [7:0]  ENRG_OFS    = 8'h04;
  localparam logic [7:0]  RANGE_OFS   = 8'h08;
  // Reset values and writable masks
  localparam logic [31:0] CFG_RST     = 32'h1B42_0000;
  localparam logic [31:0] CFG_WMASK   = 32'h3FFF_FDFC;
  localparam logic [15:0] ENRG_RST    = 16'h0000;
  localparam logic [15:0] ENRG_WMASK  = 16'h0001;
  localparam logic [31:0] RANGE_RST   = 32'h0013_0C12;
  localparam logic [31:0] RANGE_WMASK = 32'h00FF_FFFF;
  // Highest defined gain code, fixed legacy baud code
  localparam logic [2:0]  GAIN_MAX    = 3'h5;
  localparam logic [2:0]  BAUD_FIXED  = 3'h0;
  // Timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          ZC_PULSE_NS   = 100000;
  localparam int          ZC_PULSE_CYC  = ZC_PULSE_NS / CLK_PERIOD_NS;
  // Data widths
  localparam int          SMP_W  = 24;
  localparam int          GSMP_W = 29;
  localparam int          RES_W  = 32;
  localparam int          NRG_W  = 48;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic [2:0] current_gain_code;
    logic [2:0] voltage_gain_code;
    logic [7:0] reference_trim_code;
    logic [2:0] baud_code;
    logic       zero_cross_invert;
    logic       zero_cross_pulse_mode;
    logic       zero_cross_pin_disable;
    logic       rsv9;
    logic       single_wire_enable;
    logic       temp_correction_enable;
    logic [1:0] adc_soft_reset;
    logic [1:0] adc_shutdown;
    logic       internal_reference_off;
    logic [1:0] rsv_lo;
  } mfe_cfg_t;

  typedef struct packed {
    logic [7:0] rsv;
    logic [7:0] power_shift;
    logic [7:0] current_shift;
    logic [7:0] voltage_shift;
  } mfe_range_t;
endpackage

// ---- rtl/mfe_config_bank.sv ----
// Configuration bank of the metering front end, APB slave, zero wait state
module mfe_config_bank #(
  parameter int ZC_PULSE_LEN = mfe_pkg::ZC_PULSE_CYC,
  parameter bit HAS_BAUD_SEL = 1'b1
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     srst_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [7:0]               paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  input  wire logic [1:0][23:0]         adc_sample_i,
  input  wire logic [1:0]               adc_valid_i,
  output logic      [1:0][28:0]         adc_sample_o,
  output logic      [1:0]               adc_valid_o,
  output logic      [1:0]               adc_power_on_o,
  output logic      [1:0][2:0]          gain_code_o,
  output logic      [7:0]               reference_trim_code_o,
  output logic                          internal_reference_off_o,
  output logic                          temp_correction_enable_o,
  output logic                          single_wire_enable_o,
  input  wire logic [2:0]               nv_baud_code_i,
  output logic      [2:0]               baud_code_o,
  input  wire logic                     zero_cross_event_i,
  output logic                          zero_cross_output_o,
  output logic                          zero_cross_oe_o,
  input  wire logic                     calc_valid_i,
  input  wire logic [3:0][31:0]         calc_result_i,
  output logic      [3:0][31:0]         scaled_result_o,
  output logic                          scaled_valid_o,
  output logic                          accumulate_on_o,
  output logic      [47:0]              energy_o
);

  mfe_pkg::mfe_cfg_t   cfg;
  mfe_pkg::mfe_range_t rng;
  logic [15:0]         enrg;
  logic                booted;
  logic                zc_toggle;
  logic [13:0]         zc_cnt;
  logic                wr_en;
  logic [31:0]         next_prdata;
  logic                next_slverr;
  logic [1:0][2:0]     ch_gain;

  // Writes land only on the access edge with pready high
  assign wr_en = psel_i & penable_i & pwrite_i & pready_o;

  // Read mux; unmapped addresses read zero and flag an error
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr_i)
      mfe_pkg::CFG_OFS:   next_prdata = cfg & mfe_pkg::CFG_WMASK;
      mfe_pkg::ENRG_OFS:  next_prdata = {16'h0000, enrg & mfe_pkg::ENRG_WMASK};
      mfe_pkg::RANGE_OFS: next_prdata = rng & mfe_pkg::RANGE_WMASK;
      default:            next_slverr = 1'b1;
    endcase
  end

  // Answer in the first access cycle; data is captured in setup
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & next_slverr;
      prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? next_prdata : 32'h0000_0000;
    end
  end

  // System configuration; baud field reloads from saved copy at power-up
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cfg <= mfe_pkg::CFG_RST;
    end else if (!booted) begin
      cfg.baud_code <= nv_baud_code_i;
    end else if (wr_en && paddr_i == mfe_pkg::CFG_OFS) begin
      cfg <= pwdata_i & mfe_pkg::CFG_WMASK;
    end
  end

  // Energy control and range registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      enrg <= mfe_pkg::ENRG_RST;
      rng  <= mfe_pkg::RANGE_RST;
    end else if (wr_en) begin
      if (paddr_i == mfe_pkg::ENRG_OFS) begin
        enrg <= pwdata_i[15:0] & mfe_pkg::ENRG_WMASK;
      end
      if (paddr_i == mfe_pkg::RANGE_OFS) begin
        rng <= pwdata_i & mfe_pkg::RANGE_WMASK;
      end
    end
  end

  // baud at power-up
  // The live rate is frozen at release so a software write cannot upset the link
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      booted      <= 1'b0;
      baud_code_o <= mfe_pkg::BAUD_FIXED;
    end else if (!booted) begin
      booted      <= 1'b1;
      baud_code_o <= HAS_BAUD_SEL ? nv_baud_code_i : mfe_pkg::BAUD_FIXED;
    end
  end

  // Plain control levels straight from the register
  // trim output
  assign reference_trim_code_o    = cfg.reference_trim_code;
  assign internal_reference_off_o = cfg.internal_reference_off;
  assign temp_correction_enable_o = cfg.temp_correction_enable;
  assign single_wire_enable_o     = cfg.single_wire_enable;
  assign accumulate_on_o          = enrg[0];

  assign ch_gain[0] = cfg.current_gain_code;
  assign ch_gain[1] = cfg.voltage_gain_code;

  // Per converter: index 0 current, index 1 voltage
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [2:0] eff;
    assign eff = (ch_gain[c] > mfe_pkg::GAIN_MAX) ? 3'h0 : ch_gain[c];

    // Gained sample; shutdown stops delivery, soft reset forces zero
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        adc_sample_o[c]   <= '0;
        adc_valid_o[c]    <= 1'b0;
        adc_power_on_o[c] <= 1'b1;
        gain_code_o[c]    <= 3'h3;
      end else begin
        gain_code_o[c]    <= eff;
        adc_power_on_o[c] <= ~cfg.adc_shutdown[c];
        adc_valid_o[c]    <= adc_valid_i[c] & ~cfg.adc_shutdown[c];
        if (adc_valid_i[c]) begin
          if (cfg.adc_soft_reset[c]) begin
            adc_sample_o[c] <= '0;
          end else begin
            adc_sample_o[c] <= 29'(signed'(adc_sample_i[c])) << eff;
          end
        end
      end
    end
  end

  // range shifts
  // Shift counts above 31 simply give zero; avoiding that is up to software
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      scaled_result_o <= '0;
      scaled_valid_o  <= 1'b0;
    end else begin
      scaled_valid_o <= calc_valid_i;
      if (calc_valid_i) begin
        scaled_result_o[0] <= calc_result_i[0] >> rng.power_shift;
        scaled_result_o[1] <= calc_result_i[1] >> rng.power_shift;
        scaled_result_o[2] <= calc_result_i[2] >> rng.current_shift;
        scaled_result_o[3] <= calc_result_i[3] >> rng.voltage_shift;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !enrg[0]) begin
      energy_o <= '0;
    end else if (scaled_valid_o) begin
      energy_o <= energy_o + 48'(scaled_result_o[0]);
    end
  end

  // pulse timer
  // Pulse length counter is wide enough for the default of 10000 cycles
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      zc_cnt    <= '0;
      zc_toggle <= 1'b0;
    end else begin
      if (zero_cross_event_i) begin
        zc_cnt    <= 14'(ZC_PULSE_LEN);
        zc_toggle <= ~zc_toggle;
      end else if (zc_cnt != '0) begin
        zc_cnt <= zc_cnt - 14'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      zero_cross_output_o <= 1'b0;
      zero_cross_oe_o     <= 1'b0;
    end else begin
      zero_cross_oe_o <= ~cfg.zero_cross_pin_disable;
      if (cfg.zero_cross_pin_disable) begin
        zero_cross_output_o <= 1'b0;
      end else if (cfg.zero_cross_pulse_mode) begin
        zero_cross_output_o <= (zc_cnt != '0) ^ cfg.zero_cross_invert;
      end else begin
        zero_cross_output_o <= zc_toggle ^ cfg.zero_cross_invert;
      end
    end
  end

  // Checks on the behaviour above
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  property p_gain_map;
    adc_valid_i[0] && cfg.current_gain_code <= mfe_pkg::GAIN_MAX
      |=> gain_code_o[0] == $past(cfg.current_gain_code);
  endproperty
  a_gain_map: assert property (p_gain_map)
    else $error("current gain code not applied");

  property p_gain_rsv;
    cfg.voltage_gain_code > mfe_pkg::GAIN_MAX |=> gain_code_o[1] == 3'h0;
  endproperty
  a_gain_rsv: assert property (p_gain_rsv)
    else $error("reserved gain not treated as unity");

  property p_soft_zero;
    adc_valid_i[1] && cfg.adc_soft_reset[1] |=> adc_sample_o[1] == '0;
  endproperty
  a_soft_zero: assert property (p_soft_zero)
    else $error("soft reset sample not zero");

  property p_shutdown;
    cfg.adc_shutdown[0] |=> !adc_power_on_o[0] && !adc_valid_o[0];
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown converter still active");

  property p_wake;
    $fell(cfg.adc_shutdown[1]) |-> ##1 adc_power_on_o[1];
  endproperty
  a_wake: assert property (p_wake)
    else $error("converter not powered after shutdown cleared");

  property p_baud_hold;
    booted && $past(booted) |-> $stable(baud_code_o);
  endproperty
  a_baud_hold: assert property (p_baud_hold)
    else $error("baud changed after power-up");

  property p_zc_pulse;
    zero_cross_event_i && cfg.zero_cross_pulse_mode && !cfg.zero_cross_invert
      && !cfg.zero_cross_pin_disable |=> ##1 zero_cross_output_o [*8];
  endproperty
  a_zc_pulse: assert property (p_zc_pulse)
    else $error("zero-cross pulse too short");

  property p_zc_dis;
    cfg.zero_cross_pin_disable |=> !zero_cross_oe_o && !zero_cross_output_o;
  endproperty
  a_zc_dis: assert property (p_zc_dis)
    else $error("disabled zero-cross pin still driven");

  property p_rsv_read;
    psel_i && !penable_i && !pwrite_i && paddr_i == mfe_pkg::CFG_OFS
      |=> prdata_o[31:30] == 2'h0 && prdata_o[9] == 1'b0 && prdata_o[1:0] == 2'h0;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("reserved config bits read nonzero");

  property p_energy_clr;
    !enrg[0] |=> energy_o == '0;
  endproperty
  a_energy_clr: assert property (p_energy_clr)
    else $error("energy not cleared while off");

  property p_power_shift;
    calc_valid_i |=> scaled_result_o[1] == ($past(calc_result_i[1]) >> $past(rng.power_shift));
  endproperty
  a_power_shift: assert property (p_power_shift)
    else $error("reactive power shift wrong");

  property p_gain_rsv_cur;
    cfg.current_gain_code > mfe_pkg::GAIN_MAX |=> gain_code_o[0] == 3'h0;
  endproperty
  a_gain_rsv_cur: assert property (p_gain_rsv_cur)
    else $error("reserved current gain not treated as unity");

  property p_gain_map_v;
    cfg.voltage_gain_code <= mfe_pkg::GAIN_MAX
      |=> gain_code_o[1] == $past(cfg.voltage_gain_code);
  endproperty
  a_gain_map_v: assert property (p_gain_map_v)
    else $error("voltage gain code not applied");

  property p_soft_zero_cur;
    adc_valid_i[0] && cfg.adc_soft_reset[0] |=> adc_sample_o[0] == '0;
  endproperty
  a_soft_zero_cur: assert property (p_soft_zero_cur)
    else $error("current converter soft reset sample not zero");

  property p_soft_run;
    adc_valid_i[1] && !cfg.adc_shutdown[1] |=> adc_valid_o[1];
  endproperty
  a_soft_run: assert property (p_soft_run)
    else $error("running converter lost a sample");

  property p_shutdown_v;
    cfg.adc_shutdown[1] |=> !adc_power_on_o[1] && !adc_valid_o[1];
  endproperty
  a_shutdown_v: assert property (p_shutdown_v)
    else $error("shutdown voltage converter still active");

  property p_trim_wr;
    booted && wr_en && paddr_i == mfe_pkg::CFG_OFS
      |=> reference_trim_code_o == $past(pwdata_i[23:16]);
  endproperty
  a_trim_wr: assert property (p_trim_wr)
    else $error("reference trim write not kept");

  property p_enrg_read;
    psel_i && !penable_i && !pwrite_i && paddr_i == mfe_pkg::ENRG_OFS
      |=> prdata_o[31:1] == 31'h0000_0000;
  endproperty
  a_enrg_read: assert property (p_enrg_read)
    else $error("reserved energy control bits read nonzero");

  property p_zc_toggle;
    zero_cross_event_i && !cfg.zero_cross_pulse_mode && !cfg.zero_cross_pin_disable
      ##1 !cfg.zero_cross_pulse_mode && !cfg.zero_cross_pin_disable && $stable(cfg.zero_cross_invert)
      |=> zero_cross_output_o != $past(zero_cross_output_o);
  endproperty
  a_zc_toggle: assert property (p_zc_toggle)
    else $error("zero-cross output did not toggle");

  property p_zc_inv;
    zero_cross_event_i && cfg.zero_cross_pulse_mode && cfg.zero_cross_invert
      ##1 cfg.zero_cross_pulse_mode && cfg.zero_cross_invert |=> !zero_cross_output_o;
  endproperty
  a_zc_inv: assert property (p_zc_inv)
    else $error("inverted zero-cross pulse not low");

  property p_zc_oe;
    !cfg.zero_cross_pin_disable |=> zero_cross_oe_o;
  endproperty
  a_zc_oe: assert property (p_zc_oe)
    else $error("enabled zero-cross pin not driven");

  property p_energy_acc;
    enrg[0] && scaled_valid_o
      |=> energy_o == $past(energy_o) + 48'($past(scaled_result_o[0]));
  endproperty
  a_energy_acc: assert property (p_energy_acc)
    else $error("energy did not accumulate");

  property p_cur_shift;
    calc_valid_i |=> scaled_result_o[2] == ($past(calc_result_i[2]) >> $past(rng.current_shift));
  endproperty
  a_cur_shift: assert property (p_cur_shift)
    else $error("rms current shift wrong");

  property p_volt_shift;
    calc_valid_i |=> scaled_result_o[3] == ($past(calc_result_i[3]) >> $past(rng.voltage_shift));
  endproperty
  a_volt_shift: assert property (p_volt_shift)
    else $error("rms voltage shift wrong");

  property p_baud_load;
    !booted |=> baud_code_o == (HAS_BAUD_SEL ? $past(nv_baud_code_i) : mfe_pkg::BAUD_FIXED);
  endproperty
  a_baud_load: assert property (p_baud_load)
    else $error("power-up baud code not taken");

endmodule

// ---- verif/mfe_config_bank_bench.sv ----
// Compares a design value against an expected one and counts both outcomes
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module mfe_config_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                sys_clk_i, srst_i, psel_i, penable_i, pwrite_i;
  logic [7:0]          paddr_i, trim;
  logic [31:0]         pwdata_i, prdata_o, rd;
  logic                pready_o, pslverr_o, er, ref_off, tc_en, sw_en;
  logic [1:0][23:0]    adc_sample_i;
  logic [1:0][28:0]    adc_sample_o;
  logic [1:0]          adc_valid_i, adc_valid_o, power_on;
  logic [1:0][2:0]     gain_code;
  logic [2:0]          nv_baud, baud, baud_legacy;
  logic                zc_ev, zc_out, zc_oe, calc_v, scaled_v, acc_on;
  logic [3:0][31:0]    calc_r, scaled;
  logic [47:0]         energy;
  int                  n_errors, comparisons;

  // Pulse length shortened so the pulse-mode walk stays brief
  mfe_config_bank #(.ZC_PULSE_LEN(12), .HAS_BAUD_SEL(1'b1)) dut_u (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .adc_sample_i(adc_sample_i),
    .adc_valid_i(adc_valid_i), .adc_sample_o(adc_sample_o), .adc_valid_o(adc_valid_o),
    .adc_power_on_o(power_on), .gain_code_o(gain_code), .reference_trim_code_o(trim),
    .internal_reference_off_o(ref_off), .temp_correction_enable_o(tc_en),
    .single_wire_enable_o(sw_en), .nv_baud_code_i(nv_baud), .baud_code_o(baud),
    .zero_cross_event_i(zc_ev), .zero_cross_output_o(zc_out), .zero_cross_oe_o(zc_oe),
    .calc_valid_i(calc_v), .calc_result_i(calc_r), .scaled_result_o(scaled),
    .scaled_valid_o(scaled_v), .accumulate_on_o(acc_on), .energy_o(energy));

  // Older version without a baud field must keep the fixed rate
  mfe_config_bank #(.ZC_PULSE_LEN(12), .HAS_BAUD_SEL(1'b0)) legacy_u (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(),
    .pready_o(), .pslverr_o(), .adc_sample_i(adc_sample_i), .adc_valid_i(adc_valid_i),
    .adc_sample_o(), .adc_valid_o(), .adc_power_on_o(), .gain_code_o(),
    .reference_trim_code_o(), .internal_reference_off_o(), .temp_correction_enable_o(),
    .single_wire_enable_o(), .nv_baud_code_i(nv_baud), .baud_code_o(baud_legacy),
    .zero_cross_event_i(zc_ev), .zero_cross_output_o(), .zero_cross_oe_o(),
    .calc_valid_i(calc_v), .calc_result_i(calc_r), .scaled_result_o(),
    .scaled_valid_o(), .accumulate_on_o(), .energy_o());

  // Clock and time-zero input values
  initial begin
    sys_clk_i = 0; srst_i = 1; psel_i = 0; penable_i = 0; pwrite_i = 0; paddr_i = 8'h00;
    pwdata_i = 32'h0; adc_sample_i = '0; adc_valid_i = 2'b00; nv_baud = 3'h0;
    zc_ev = 0; calc_v = 0; calc_r = '0; n_errors = 0; comparisons = 0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1;
    // Only the watchdog ends a wait that never sees pready
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    // Callers look at outputs only once the write edge has settled
    @(negedge sys_clk_i);
  endtask

  task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(rd, exp)
  endtask

  task automatic smp(input logic [23:0] s);
    @(posedge sys_clk_i); adc_sample_i <= {s, s}; adc_valid_i <= 2'b11;
    @(posedge sys_clk_i); adc_valid_i <= 2'b00;
    @(negedge sys_clk_i);
  endtask

  task automatic calc(input logic [31:0] v);
    @(posedge sys_clk_i); calc_r <= {v, v, v, v}; calc_v <= 1;
    @(posedge sys_clk_i); calc_v <= 0;
    @(negedge sys_clk_i);
  endtask

  task automatic zc();
    @(posedge sys_clk_i); zc_ev <= 1;
    @(posedge sys_clk_i); zc_ev <= 0;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  // Every saved baud code is taken only across a power-up, then reset values
  task automatic t_baud();
    for (int b = 0; b < 8; b++) begin
      @(posedge sys_clk_i); srst_i <= 1; nv_baud <= 3'(b);
      repeat (20) @(posedge sys_clk_i);
      srst_i <= 0;
      repeat (3) @(posedge sys_clk_i);
      `CHK(baud, 3'(b))
      `CHK(baud_legacy, 3'h0)
      rdck(mfe_pkg::CFG_OFS, 32'h1B42_0000 | (32'(b) << 13));
    end
    `CHK(gain_code, 6'h1B)
    rdck(mfe_pkg::ENRG_OFS, 32'h0);
    rdck(mfe_pkg::RANGE_OFS, 32'h0013_0C12);
  endtask

  // All ones written: unimplemented bits stay zero, baud output keeps power-up code
  task automatic t_regs();
    apb(1'b1, mfe_pkg::CFG_OFS, 32'hFFFF_FFFF);
    rdck(mfe_pkg::CFG_OFS, 32'h3FFF_FDFC);
    `CHK(baud, 3'h7)
    `CHK({trim, ref_off, tc_en, sw_en}, 11'h7FF)
    apb(1'b1, mfe_pkg::CFG_OFS, 32'h0000_0000);
    `CHK({ref_off, tc_en, sw_en}, 3'h0)
    `CHK(baud, 3'h7)
    apb(1'b1, mfe_pkg::RANGE_OFS, 32'hFFFF_FFFF);
    rdck(mfe_pkg::RANGE_OFS, 32'h00FF_FFFF);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    `CHK(er, 1'b1)
    rdck(8'h0C, 32'h0);
  endtask

  // Gain codes, reserved ones included, shift the converted sample
  task automatic t_gain();
    logic [2:0] e;
    for (int k = 0; k < 8; k++) begin
      e = (k > 5) ? 3'h0 : 3'(k);
      apb(1'b1, mfe_pkg::CFG_OFS, {2'b00, 3'(k), 3'(k), 24'h42_0000});
      smp(24'h000003);
      `CHK(adc_sample_o, {29'(3) << e, 29'(3) << e})
    end
  endtask

  // Soft reset zeroes samples but keeps valids; shutdown drops valids and power
  task automatic t_rst_sd();
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, mfe_pkg::CFG_OFS, 32'h0042_0000 | (32'(m) << 5));
      smp(24'h000003);
      `CHK(adc_sample_o[0], m[0] ? 29'h0 : 29'h3)
      `CHK(adc_sample_o[1], m[1] ? 29'h0 : 29'h3)
      `CHK(adc_valid_o, 2'b11)
      apb(1'b1, mfe_pkg::CFG_OFS, 32'h0042_0000 | (32'(m) << 3));
      smp(24'h000003);
      `CHK({power_on, adc_valid_o}, {~2'(m), ~2'(m)})
    end
    apb(1'b1, mfe_pkg::CFG_OFS, 32'h0042_0000);
    smp(24'h000003);
    `CHK({power_on, adc_valid_o}, 4'hF)
  endtask

  // Range bytes scale each result; energy sums active power only while on
  task automatic t_calc();
    apb(1'b1, mfe_pkg::RANGE_OFS, 32'h0002_0104);
    apb(1'b1, mfe_pkg::ENRG_OFS, 32'hFFFF_FFFF);
    rdck(mfe_pkg::ENRG_OFS, 32'h1);
    calc(32'h100);
    `CHK(scaled, {32'h10, 32'h80, 32'h40, 32'h40})
    `CHK(scaled_v, 1'b1)
    calc(32'h100);
    @(negedge sys_clk_i);
    `CHK(energy, 48'h80)
    apb(1'b1, mfe_pkg::ENRG_OFS, 32'h0);
    @(negedge sys_clk_i);
    `CHK({acc_on, energy}, 49'h0)
  endtask

  // Toggle, pulse, inverted pulse, then a disabled pin
  task automatic t_zc();
    logic b;
    apb(1'b1, mfe_pkg::CFG_OFS, 32'h0042_0000);
    repeat (2) @(negedge sys_clk_i);
    `CHK(zc_oe, 1'b1)
    b = zc_out;
    zc();
    `CHK(zc_out, ~b)
    zc();
    `CHK(zc_out, b)
    apb(1'b1, mfe_pkg::CFG_OFS, 32'h0042_0800);
    zc();
    `CHK(zc_out, 1'b1)
    repeat (11) @(negedge sys_clk_i);
    `CHK(zc_out, 1'b1)
    @(negedge sys_clk_i);
    `CHK(zc_out, 1'b0)
    apb(1'b1, mfe_pkg::CFG_OFS, 32'h0042_1800);
    repeat (2) @(negedge sys_clk_i);
    `CHK(zc_out, 1'b1)
    zc();
    `CHK(zc_out, 1'b0)
    apb(1'b1, mfe_pkg::CFG_OFS, 32'h0042_0400);
    repeat (2) @(negedge sys_clk_i);
    `CHK({zc_oe, zc_out}, 2'b00)
  endtask

  // Main sequence
  initial begin
    t_baud();
    t_regs();
    t_gain();
    t_rst_sd();
    t_calc();
    t_zc();
    close_out();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    close_out();
  end
endmodule
